/* File: rtl/ccsc_pkg.sv */
/*
 * package for the cpu core status and control block: register layouts,
 * reset values, opcodes and timing counts.
 * assumes: shared by the core top and its divider and multiplier modules.
 */
package ccsc_pkg;

	localparam int PC_W = 23;
	localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
	localparam int WREG_W = 16;
	localparam int WREG_N = 16;
	localparam logic [3:0] SP_IDX = 4'hF;
	localparam logic [3:0] QUOT_IDX = 4'h0;
	localparam logic [3:0] REM_IDX = 4'h1;

	// alu_status field positions
	localparam int ST_C = 0;
	localparam int ST_Z = 1;
	localparam int ST_OV = 2;
	localparam int ST_N = 3;
	localparam int ST_RA = 4;
	localparam int ST_IPL_LO = 5;
	localparam int ST_IPL_HI = 7;
	localparam int ST_DC = 8;
	localparam logic [15:0] ALU_STATUS_RESET = 16'h0000;
	localparam logic [15:0] ALU_STATUS_WMASK = 16'h01EF;

	// cpu_control field positions
	localparam int CC_PSV = 2;
	localparam int CC_UPPER_PRIORITY_BIT = 3;
	localparam logic [15:0] CPU_CONTROL_RESET = 16'h0000;

	localparam int NEST_DIS_BIT = 15;
	localparam logic [7:0] VIS_PAGE_RESET = 8'h00;
	localparam logic [2:0] IPL_USER_OFF = 3'h7;

	// data space window for program space visibility
	localparam logic [15:0] PSV_BASE = 16'h8000;

	localparam int DIV_CYCLES = 19;
	localparam int DIV_STEPS = 16;

	typedef enum logic [3:0] {
		CCSC_OP_NOP,
		CCSC_OP_ADD,
		CCSC_OP_SUB,
		CCSC_OP_AND,
		CCSC_OP_IOR,
		CCSC_OP_XOR,
		CCSC_OP_MUL,
		CCSC_OP_DIV,
		CCSC_OP_FLOW,
		CCSC_OP_MOVD,
		CCSC_OP_TBL
	} ccsc_op_t;

	typedef enum logic [1:0] {
		CCSC_MUL_SS,
		CCSC_MUL_UU,
		CCSC_MUL_SU,
		CCSC_MUL_US
	} ccsc_mul_t;

endpackage : ccsc_pkg

/* File: rtl/ccsc_div_if.sv */
/*
 * carrier between the core top and its iterative divider.
 * assumes: one clock; start is a one-cycle pulse from the core.
 */
interface ccsc_div_if;
	logic start;
	logic step_en;
	logic is_signed;
	logic long_div;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic busy;
	logic done;
	logic [15:0] quot;
	logic [15:0] rem;

	modport core (output start, output step_en, output is_signed, output long_div,
		output dividend, output divisor, input busy, input done, input quot, input rem);
	modport div (input start, input step_en, input is_signed, input long_div,
		input dividend, input divisor, output busy, output done, output quot, output rem);
endinterface : ccsc_div_if

/* File: rtl/ccsc_divider.sv */
/*
 * iterative non-restoring divider, one quotient bit per step.
 * assumes: step_en may be held low to let the core take an interrupt
 * between steps; operands are stable while start is high.
 */
module ccsc_divider (
	input wire logic clk,
	input wire logic rst_n,
	ccsc_div_if.div d
);
	logic [4:0] cnt;
	logic [16:0] part_rem;
	logic [31:0] work;
	logic [15:0] dvs;
	logic neg_q;
	logic neg_r;
	logic [16:0] trial;
	logic [15:0] fin_q;
	logic [16:0] fin_r;
	logic sgn_a;
	logic [31:0] mag;

	// magnitude of the dividend; a long dividend seeds the remainder with its upper half
	assign sgn_a = d.is_signed && (d.long_div ? d.dividend[31] : d.dividend[15]);
	always_comb begin
		if (d.long_div) begin
			mag = sgn_a ? 32'(-d.dividend) : d.dividend;
		end else begin
			mag = {16'h0000, (sgn_a ? 16'(-d.dividend[15:0]) : d.dividend[15:0])};
		end
	end

	always_comb begin
		if (part_rem[16]) begin
			trial = {part_rem[15:0], work[31]} + {1'b0, dvs};
		end else begin
			trial = {part_rem[15:0], work[31]} - {1'b0, dvs};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 5'h00;
			part_rem <= 17'h00000;
			work <= 32'h00000000;
			dvs <= 16'h0000;
			neg_q <= 1'b0;
			neg_r <= 1'b0;
		end else if (d.start) begin
			cnt <= 5'(ccsc_pkg::DIV_STEPS);
			part_rem <= {1'b0, mag[31:16]};
			neg_r <= sgn_a;
			neg_q <= sgn_a ^ (d.is_signed && d.divisor[15]);
			dvs <= (d.is_signed && d.divisor[15]) ? 16'(-d.divisor) : d.divisor;
			work <= {mag[15:0], 16'h0000};
		end else if (d.step_en && cnt != 5'h00) begin
			part_rem <= trial;
			work <= {work[30:0], ~trial[16]};
			cnt <= cnt - 5'h01;
		end
	end

	always_comb begin
		fin_r = part_rem[16] ? part_rem + {1'b0, dvs} : part_rem;
		fin_q = work[15:0];
	end

	assign d.busy = cnt != 5'h00;
	assign d.done = d.step_en && cnt == 5'h01;
	assign d.quot = neg_q ? 16'(-fin_q) : fin_q;
	assign d.rem = neg_r ? 16'(-fin_r[15:0]) : fin_r[15:0];
endmodule : ccsc_divider

/* File: rtl/ccsc_mul.sv */
/*
 * single-cycle 17 x 17 multiplier covering signed, unsigned and mixed
 * 16 x 16 products and unsigned 8 x 8 products.
 * assumes: purely combinational; the core registers the result.
 */
module ccsc_mul (
	input wire logic [15:0] a,
	input wire logic [15:0] b,
	input wire ccsc_pkg::ccsc_mul_t mode,
	input wire logic byte_mode,
	output logic [31:0] prod
);
	logic [16:0] ax;
	logic [16:0] bx;
	logic signed [33:0] full;

	always_comb begin
		if (byte_mode) begin
			ax = {9'h000, a[7:0]};
			bx = {9'h000, b[7:0]};
		end else begin
			ax = {(mode == ccsc_pkg::CCSC_MUL_SS || mode == ccsc_pkg::CCSC_MUL_SU)
				&& a[15], a};
			bx = {(mode == ccsc_pkg::CCSC_MUL_SS || mode == ccsc_pkg::CCSC_MUL_US)
				&& b[15], b};
		end
		full = $signed(ax) * $signed(bx);
		prod = full[31:0];
	end
endmodule : ccsc_mul

/* File: rtl/ccsc_core.sv */
/*
 * status and control portion of a 16-bit cpu core: program counter,
 * working registers, repeat loop, multiplier, divider, status flags,
 * priority level and control register.
 * assumes: the decoder outside presents one decoded instruction per
 * cycle with instr_valid; the interrupt controller reads cpu_level.
 */
// Functional notes
// - program counter is 23 bits wide
// - single cycle except flow, double move, table, divide
// - repeat loop without overhead, interruptible anywhere
// - sixteen 16-bit working registers, last is stack
// - upper data half mapped by page register
// - read, register read, write, fetch per cycle
// - 17x17 multiplier, all sign modes, one cycle
// - iterative divide, 19 cycles, interruptible
// - vectored traps and 118 sources, seven levels
// - half carry from bit 4 or 8
// - status bits 7-5 hold priority level
// - priority bits read-only when nesting disabled
// - upper priority bit concatenated above status bits
// - loop active flag set during repeat loop
// - negative flag follows result sign
// - overflow flag on signed overflow
// - zero flag cleared by nonzero, set by zero
// - carry flag on carry out of msb
// - upper priority bit hardware set, software cleared
// - visibility enable maps program space into data
// - carry and half carry are inverted borrows on subtract
// - divide leaves quotient in reg zero, remainder one
module ccsc_core (
	input wire logic clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire ccsc_pkg::ccsc_op_t instr_op,
	input wire logic instr_byte,
	input wire logic [3:0] instr_rd,
	input wire logic [3:0] instr_rs,
	input wire logic [15:0] instr_mem_data,
	input wire logic instr_use_mem,
	input wire logic instr_write_mem,
	input wire ccsc_pkg::ccsc_mul_t instr_mul_mode,
	input wire logic instr_div_signed,
	input wire logic instr_div_long,
	input wire logic [22:0] instr_target,
	input wire logic repeat_load,
	input wire logic [13:0] repeat_count,
	input wire logic irq_take,
	input wire logic irq_return,
	input wire logic [2:0] irq_level,
	input wire logic trap_take,
	input wire logic nesting_disable,
	input wire logic sfr_write,
	input wire logic sfr_sel_status,
	input wire logic sfr_sel_control,
	input wire logic sfr_sel_page,
	input wire logic [15:0] sfr_wdata,
	input wire logic [15:0] data_addr,
	output logic [22:0] pc,
	output logic stall,
	output logic [15:0] alu_status,
	output logic [15:0] cpu_control,
	output logic [7:0] visibility_page_register,
	output logic [3:0] cpu_level,
	output logic user_irq_disabled,
	output logic psv_hit,
	output logic [22:0] psv_prog_addr,
	output logic [15:0] stack_pointer_register,
	output logic [15:0] mem_wdata,
	output logic mem_we,
	output logic [15:0] rd_value
);
	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_q1;
	logic rst_n;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ----------------------------------------------------------------
	// operands and arithmetic
	// ----------------------------------------------------------------
	logic [15:0] wreg [ccsc_pkg::WREG_N];
	logic [15:0] opa;
	logic [15:0] opb;
	logic [16:0] sum;
	logic [4:0] nib;
	logic [8:0] low;
	logic [15:0] res;
	logic f_c;
	logic f_dc;
	logic f_ov;
	logic f_n;
	logic f_nz;
	logic arith;
	logic logic_op;
	logic is_sub;
	logic [31:0] prod;
	logic [3:0] multi_left;
	logic is_multi;
	logic exec;
	ccsc_div_if dv ();

	assign opa = wreg[instr_rd];
	assign opb = instr_use_mem ? instr_mem_data : wreg[instr_rs];
	assign is_sub = instr_op == ccsc_pkg::CCSC_OP_SUB;
	assign arith = instr_op == ccsc_pkg::CCSC_OP_ADD || is_sub;
	assign logic_op = instr_op == ccsc_pkg::CCSC_OP_AND || instr_op == ccsc_pkg::CCSC_OP_IOR
		|| instr_op == ccsc_pkg::CCSC_OP_XOR;

	ccsc_mul u_mul (
		.a(opa),
		.b(opb),
		.mode(instr_mul_mode),
		.byte_mode(instr_byte),
		.prod(prod)
	);

	always_comb begin
		// subtract as a + ~b + 1 so carries read as not-borrow
		sum = {1'b0, opa} + {1'b0, is_sub ? ~opb : opb} + {16'h0000, is_sub};
		nib = {1'b0, opa[3:0]} + {1'b0, is_sub ? ~opb[3:0] : opb[3:0]} + {4'h0, is_sub};
		low = {1'b0, opa[7:0]} + {1'b0, is_sub ? ~opb[7:0] : opb[7:0]} + {8'h00, is_sub};
		case (instr_op)
			ccsc_pkg::CCSC_OP_AND: res = opa & opb;
			ccsc_pkg::CCSC_OP_IOR: res = opa | opb;
			ccsc_pkg::CCSC_OP_XOR: res = opa ^ opb;
			ccsc_pkg::CCSC_OP_MUL: res = prod[15:0];
			default: res = sum[15:0];
		endcase
		if (instr_byte) begin
			f_c = low[8];
			f_dc = nib[4];
			f_n = res[7];
			f_ov = (opa[7] == (is_sub ? ~opb[7] : opb[7])) && (res[7] != opa[7]);
			f_nz = res[7:0] != 8'h00;
		end else begin
			f_c = sum[16];
			f_dc = low[8];
			f_n = res[15];
			f_ov = (opa[15] == (is_sub ? ~opb[15] : opb[15])) && (res[15] != opa[15]);
			f_nz = res != 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// multi-cycle sequencing
	// ----------------------------------------------------------------
	logic [13:0] rpt_left;
	logic rpt_active;
	logic div_tail;
	logic [1:0] tail_cnt;

	// flow change, double move and table ops take a second cycle
	assign is_multi = instr_op == ccsc_pkg::CCSC_OP_FLOW || instr_op == ccsc_pkg::CCSC_OP_MOVD
		|| instr_op == ccsc_pkg::CCSC_OP_TBL;
	assign stall = (multi_left != 4'h0) || dv.busy || div_tail;
	assign exec = instr_valid && !stall && !irq_take && !trap_take;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			multi_left <= 4'h0;
		end else if (multi_left != 4'h0) begin
			multi_left <= multi_left - 4'h1;
		end else if (exec && is_multi) begin
			multi_left <= 4'h1;
		end
	end

	// divider: one set-up cycle, sixteen steps, two finishing cycles
	assign dv.start = exec && instr_op == ccsc_pkg::CCSC_OP_DIV;
	assign dv.step_en = !irq_take && !trap_take;
	assign dv.is_signed = instr_div_signed;
	assign dv.long_div = instr_div_long;
	assign dv.dividend = instr_div_long ? {wreg[instr_rd + 4'h1], opa} : {16'h0000, opa};
	assign dv.divisor = wreg[instr_rs];

	ccsc_divider u_div (
		.clk(clk),
		.rst_n(rst_n),
		.d(dv.div)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_tail <= 1'b0;
			tail_cnt <= 2'h0;
		end else if (dv.done) begin
			div_tail <= 1'b1;
			tail_cnt <= 2'(ccsc_pkg::DIV_CYCLES - ccsc_pkg::DIV_STEPS - 2);
		end else if (div_tail && dv.step_en) begin
			if (tail_cnt == 2'h0) begin
				div_tail <= 1'b0;
			end else begin
				tail_cnt <= tail_cnt - 2'h1;
			end
		end
	end

	// repeat: the following instruction reissues with no extra cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rpt_left <= 14'h0000;
		end else if (repeat_load && exec) begin
			rpt_left <= repeat_count + 14'h0001;
		end else if (exec && rpt_active) begin
			rpt_left <= rpt_left - 14'h0001;
		end
	end
	assign rpt_active = rpt_left != 14'h0000;

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= ccsc_pkg::PC_RESET;
		end else if (exec && instr_op == ccsc_pkg::CCSC_OP_FLOW) begin
			pc <= instr_target;
		end else if (exec && !(rpt_active && !repeat_load)) begin
			// held during repeat so an interrupt resumes the loop in place
			pc <= pc + 23'h000002;
		end
	end

	// ----------------------------------------------------------------
	// working registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < ccsc_pkg::WREG_N; i++) begin
				wreg[i] <= 16'h0000;
			end
		end else if (div_tail && tail_cnt == 2'h0 && dv.step_en) begin
			wreg[ccsc_pkg::QUOT_IDX] <= dv.quot;
			wreg[ccsc_pkg::REM_IDX] <= dv.rem;
		end else if (exec && instr_op == ccsc_pkg::CCSC_OP_MUL) begin
			wreg[instr_rd] <= prod[15:0];
			wreg[instr_rd + 4'h1] <= prod[31:16];
		end else if (exec && (arith || logic_op) && !instr_write_mem) begin
			if (instr_byte) begin
				wreg[instr_rd][7:0] <= res[7:0];
			end else begin
				wreg[instr_rd] <= res;
			end
		end
	end
	assign stack_pointer_register = wreg[ccsc_pkg::SP_IDX];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_wdata <= 16'h0000;
			mem_we <= 1'b0;
			rd_value <= 16'h0000;
		end else begin
			mem_we <= exec && instr_write_mem && (arith || logic_op);
			mem_wdata <= res;
			rd_value <= opa;
		end
	end

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	logic [2:0] ipl;
	logic st_c;
	logic st_z;
	logic st_ov;
	logic st_n;
	logic st_dc;
	logic sw_st;

	assign sw_st = sfr_write && sfr_sel_status;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{st_dc, st_n, st_ov, st_z, st_c} <= 5'h00;
		end else if (exec && arith) begin
			st_c <= f_c;
			st_dc <= f_dc;
			st_ov <= f_ov;
			st_n <= f_n;
			// a zero result sets it, any other result clears it
			st_z <= !f_nz;
		end else if (exec && logic_op) begin
			st_n <= f_n;
			st_z <= !f_nz;
		end else if (sw_st) begin
			st_c <= sfr_wdata[ccsc_pkg::ST_C];
			st_z <= sfr_wdata[ccsc_pkg::ST_Z];
			st_ov <= sfr_wdata[ccsc_pkg::ST_OV];
			st_n <= sfr_wdata[ccsc_pkg::ST_N];
			st_dc <= sfr_wdata[ccsc_pkg::ST_DC];
		end
	end

	// ----------------------------------------------------------------
	// priority level and control
	// ----------------------------------------------------------------
	logic upper_priority_bit;
	logic psv_en;
	logic [2:0] saved_ipl;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ipl <= 3'h0;
			saved_ipl <= 3'h0;
		end else if (irq_take) begin
			saved_ipl <= ipl;
			ipl <= irq_level;
		end else if (irq_return) begin
			ipl <= saved_ipl;
		end else if (sw_st && !nesting_disable) begin
			ipl <= sfr_wdata[ccsc_pkg::ST_IPL_HI:ccsc_pkg::ST_IPL_LO];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upper_priority_bit <= 1'b0;
		end else if (trap_take) begin
			upper_priority_bit <= 1'b1;
		end else if (sfr_write && sfr_sel_control && !sfr_wdata[ccsc_pkg::CC_UPPER_PRIORITY_BIT]) begin
			upper_priority_bit <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			psv_en <= 1'b0;
			visibility_page_register <= ccsc_pkg::VIS_PAGE_RESET;
		end else begin
			if (sfr_write && sfr_sel_control) begin
				psv_en <= sfr_wdata[ccsc_pkg::CC_PSV];
			end
			if (sfr_write && sfr_sel_page) begin
				visibility_page_register <= sfr_wdata[7:0];
			end
		end
	end

	always_comb begin
		alu_status = ccsc_pkg::ALU_STATUS_RESET;
		alu_status[ccsc_pkg::ST_C] = st_c;
		alu_status[ccsc_pkg::ST_Z] = st_z;
		alu_status[ccsc_pkg::ST_OV] = st_ov;
		alu_status[ccsc_pkg::ST_N] = st_n;
		alu_status[ccsc_pkg::ST_RA] = rpt_active;
		alu_status[ccsc_pkg::ST_IPL_HI:ccsc_pkg::ST_IPL_LO] = ipl;
		alu_status[ccsc_pkg::ST_DC] = st_dc;
		cpu_control = ccsc_pkg::CPU_CONTROL_RESET;
		cpu_control[ccsc_pkg::CC_UPPER_PRIORITY_BIT] = upper_priority_bit;
		cpu_control[ccsc_pkg::CC_PSV] = psv_en;
	end

	assign cpu_level = {upper_priority_bit, ipl};
	assign user_irq_disabled = upper_priority_bit || ipl == ccsc_pkg::IPL_USER_OFF;

	// upper data half maps onto a 16k-word page of program space
	assign psv_hit = psv_en && data_addr[15];
	assign psv_prog_addr = {visibility_page_register, data_addr[14:0]};

endmodule : ccsc_core

/* File: dv/ccsc_sva.sv */
/*
 * concurrent checks on the ports of the core status and control block.
 * assumes: bound to ccsc_core; one clock; rstn active low.
 */
module ccsc_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire ccsc_pkg::ccsc_op_t instr_op,
	input wire logic [3:0] instr_rd,
	input wire logic instr_write_mem,
	input wire logic irq_take,
	input wire logic irq_return,
	input wire logic trap_take,
	input wire logic nesting_disable,
	input wire logic sfr_write,
	input wire logic sfr_sel_status,
	input wire logic sfr_sel_control,
	input wire logic [15:0] data_addr,
	input wire logic stall,
	input wire logic [15:0] alu_status,
	input wire logic [15:0] cpu_control,
	input wire logic [3:0] cpu_level,
	input wire logic user_irq_disabled,
	input wire logic psv_hit,
	input wire logic [15:0] stack_pointer_register,
	input wire logic [15:0] rd_value
);
	// --------------------------------
	// helpers and sequences
	// --------------------------------
	logic take;
	assign take = instr_valid && !stall && !irq_take && !trap_take;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence s_div_go;
		take && instr_op == ccsc_pkg::CCSC_OP_DIV;
	endsequence
	sequence s_div_hold;
		stall [*8] ##1 stall [*8];
	endsequence
	// --------------------------------
	// assertions
	// --------------------------------
	a_level_concat: assert property (cpu_level == {cpu_control[3], alu_status[7:5]})
		else $error("cpu level not formed from priority bits");
	a_user_irq_off: assert property (
		user_irq_disabled == (cpu_control[3] || alu_status[7:5] == 3'h7))
		else $error("user interrupt disable does not follow level");
	a_ipl_locked: assert property (sfr_write && sfr_sel_status && nesting_disable
		&& !irq_take && !irq_return && !trap_take |=> $stable(alu_status[7:5]))
		else $error("priority bits written while nesting disabled");
	a_trap_sets: assert property (trap_take |=> cpu_control[3])
		else $error("trap did not set upper priority bit");
	a_sw_no_set: assert property (sfr_write && sfr_sel_control && !trap_take
		&& !cpu_control[3] |=> !cpu_control[3])
		else $error("software set the upper priority bit");
	a_psv_window: assert property (psv_hit == (cpu_control[2] && data_addr[15]))
		else $error("visibility hit wrong");
	a_div_span: assert property (s_div_go |=> s_div_hold ##[1:30] !stall)
		else $error("divide busy span wrong");
	a_flow_extra: assert property (take && instr_op inside {ccsc_pkg::CCSC_OP_FLOW,
		ccsc_pkg::CCSC_OP_MOVD, ccsc_pkg::CCSC_OP_TBL} |=> stall ##1 !stall)
		else $error("multi cycle instruction length wrong");
	a_mul_single: assert property (take && instr_op == ccsc_pkg::CCSC_OP_MUL |=> !stall)
		else $error("multiply not single cycle");
	a_stack_alias: assert property (take && instr_rd == 4'hF && !instr_write_mem
		&& instr_op inside {ccsc_pkg::CCSC_OP_AND, ccsc_pkg::CCSC_OP_IOR}
		|=> rd_value == $past(stack_pointer_register))
		else $error("stack pointer is not the last working register");
endmodule : ccsc_sva

bind ccsc_core ccsc_sva u_sva (.*);

/* File: dv/tb_top.sv */
/*
 * self-checking bench for the core status and control block.
 * assumes: ccsc_core driven directly; one instruction at a time.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic instr_valid, instr_byte, instr_use_mem, instr_write_mem, instr_div_signed;
	logic instr_div_long, repeat_load, irq_take, irq_return, trap_take, nesting_disable;
	logic sfr_write, sfr_sel_status, sfr_sel_control, sfr_sel_page, stall, user_irq_disabled;
	logic psv_hit, mem_we, ra_seen;
	ccsc_pkg::ccsc_op_t instr_op;
	ccsc_pkg::ccsc_mul_t instr_mul_mode;
	logic [3:0] instr_rd, instr_rs, cpu_level;
	logic [15:0] instr_mem_data, sfr_wdata, data_addr, alu_status, cpu_control;
	logic [15:0] stack_pointer_register, mem_wdata, rd_value;
	logic [22:0] instr_target, pc, psv_prog_addr;
	logic [13:0] repeat_count;
	logic [2:0] irq_level;
	logic [7:0] visibility_page_register;
	int num_errors = 0;
	int samples_checked = 0;
	int n;
	localparam logic [15:0] FA[4] = '{16'h7FFF, 16'hFFFF, 16'h0001, 16'h0005};
	localparam logic [15:0] FB[4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0005};
	localparam logic [15:0] FR[4] = '{16'h8000, 16'h0000, 16'h0002, 16'h0000};
	localparam logic [15:0] FS[4] = '{16'h010C, 16'h0103, 16'h0000, 16'h0103};
	localparam logic [31:0] MP[4] = '{32'h00000001, 32'hFFFE0001, 32'hFFFF0001, 32'hFFFF0001};
	localparam logic [15:0] DL[3] = '{16'h0064, 16'hFF9C, 16'h0000};
	localparam logic [15:0] DQ[3] = '{16'h000E, 16'hFFF2, 16'h2492};
	localparam logic [15:0] DR[3] = '{16'h0002, 16'hFFFE, 16'h0002};

	ccsc_core DUT (.*);

	always #4 clk = ~clk;

	// --------------------------------
	// tasks
	// --------------------------------
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] expd);
		samples_checked++;
		if (seen !== expd) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, expd);
		end
	endtask : check

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	// counts busy cycles into n, bounded
	task automatic wait_idle;
		n = 0;
		while (stall !== 1'b0 && n < 200) begin
			n++;
			step(1);
		end
		if (n == 200) begin
			num_errors++;
			final_report();
		end
	endtask : wait_idle

	// rd is also the source register; a divide takes its divisor from register 4
	task automatic exec(input ccsc_pkg::ccsc_op_t o, input logic [3:0] d, input logic [15:0] m,
		input logic u);
		step(1);
		wait_idle();
		instr_op = o;
		instr_rd = d;
		instr_rs = (o == ccsc_pkg::CCSC_OP_DIV) ? 4'h4 : d;
		instr_mem_data = m;
		instr_use_mem = u;
		instr_valid = 1'b1;
		step(1);
		instr_valid = 1'b0;
	endtask : exec

	task automatic load(input logic [3:0] r, input logic [15:0] v);
		exec(ccsc_pkg::CCSC_OP_AND, r, 16'h0000, 1'b1);
		exec(ccsc_pkg::CCSC_OP_IOR, r, v, 1'b1);
	endtask : load

	task automatic sfr(input logic [2:0] s, input logic [15:0] d);
		step(1);
		{sfr_sel_status, sfr_sel_control, sfr_sel_page} = s;
		sfr_wdata = d;
		sfr_write = 1'b1;
		step(1);
		sfr_write = 1'b0;
	endtask : sfr

	// --------------------------------
	// sequence of tests
	// --------------------------------
	initial begin
		{instr_valid, instr_byte, instr_write_mem, instr_div_signed, instr_div_long} = '0;
		{repeat_load, irq_take, irq_return, trap_take, nesting_disable} = '0;
		{sfr_write, sfr_sel_status, sfr_sel_control, sfr_sel_page, instr_use_mem} = '0;
		instr_op = ccsc_pkg::CCSC_OP_NOP;
		instr_mul_mode = ccsc_pkg::CCSC_MUL_SS;
		{instr_rd, instr_rs, instr_mem_data, sfr_wdata, data_addr} = '0;
		{instr_target, repeat_count, irq_level} = '0;
		repeat (16) @(posedge clk);
		#1;
		rstn = 1'b1;
		step(4);
		check(alu_status, ccsc_pkg::ALU_STATUS_RESET);
		check(cpu_control, ccsc_pkg::CPU_CONTROL_RESET);
		check(pc, ccsc_pkg::PC_RESET);
		for (int i = 0; i < 4; i++) begin
			load(4'h2, FA[i]);
			exec((i == 3) ? ccsc_pkg::CCSC_OP_SUB : ccsc_pkg::CCSC_OP_ADD, 4'h2, FB[i], 1'b1);
			check(alu_status, FS[i]);
			exec(ccsc_pkg::CCSC_OP_IOR, 4'h2, 16'h0000, 1'b1);
			check(rd_value, FR[i]);
		end
		instr_byte = 1'b1;
		load(4'h2, 16'h120F);
		exec(ccsc_pkg::CCSC_OP_ADD, 4'h2, 16'h0001, 1'b1);
		instr_byte = 1'b0;
		check(alu_status[8:0], 9'h100);
		for (int i = 0; i < 4; i++) begin
			instr_mul_mode = ccsc_pkg::ccsc_mul_t'(i);
			load(4'hE, 16'hFFFF);
			exec(ccsc_pkg::CCSC_OP_MUL, 4'hE, 16'h0000, 1'b0);
			check(stall, 1'b0);
			check(stack_pointer_register, MP[i][31:16]);
			exec(ccsc_pkg::CCSC_OP_IOR, 4'hE, 16'h0000, 1'b1);
			check(rd_value, MP[i][15:0]);
		end
		load(4'h4, 16'h0007);
		for (int i = 0; i < 3; i++) begin
			load(4'h2, DL[i]);
			load(4'h3, 16'h0001);
			instr_div_signed = (i == 1);
			instr_div_long = (i == 2);
			exec(ccsc_pkg::CCSC_OP_DIV, 4'h2, 16'h0000, 1'b0);
			if (i == 2) begin
				irq_level = 3'h5;
				irq_take = 1'b1;
				step(1);
				irq_take = 1'b0;
			end
			wait_idle();
			check(n + (i == 2), ccsc_pkg::DIV_CYCLES - 1 + (i == 2));
			exec(ccsc_pkg::CCSC_OP_IOR, 4'h0, 16'h0000, 1'b1);
			check(rd_value, DQ[i]);
			exec(ccsc_pkg::CCSC_OP_IOR, 4'h1, 16'h0000, 1'b1);
			check(rd_value, DR[i]);
		end
		check(alu_status[7:5], 3'h5);
		irq_return = 1'b1;
		step(1);
		irq_return = 1'b0;
		check(alu_status[7:5], 3'h0);
		load(4'h6, 16'h0000);
		repeat_count = 14'h0003;
		repeat_load = 1'b1;
		exec(ccsc_pkg::CCSC_OP_NOP, 4'h0, 16'h0000, 1'b1);
		repeat_load = 1'b0;
		exec(ccsc_pkg::CCSC_OP_ADD, 4'h6, 16'h0001, 1'b1);
		ra_seen = alu_status[4];
		// the decoder presents the repeated instruction again while the loop runs
		for (int k = 0; k < 3; k++) begin
			exec(ccsc_pkg::CCSC_OP_ADD, 4'h6, 16'h0001, 1'b1);
		end
		check(ra_seen, 1'b1);
		check(alu_status[4], 1'b0);
		exec(ccsc_pkg::CCSC_OP_IOR, 4'h6, 16'h0000, 1'b1);
		check(rd_value, 16'h0004);
		instr_target = 23'h7FFFFE;
		for (int i = 8; i < 11; i++) begin
			exec(ccsc_pkg::ccsc_op_t'(i), 4'h0, 16'h0000, 1'b1);
			check(stall, 1'b1);
			step(1);
			check(stall, 1'b0);
			if (i == 8) begin
				check(pc, 23'h7FFFFE);
			end
		end
		load(4'h7, 16'h0000);
		instr_write_mem = 1'b1;
		exec(ccsc_pkg::CCSC_OP_ADD, 4'h7, 16'h00A5, 1'b1);
		instr_write_mem = 1'b0;
		ra_seen = 1'b0;
		for (int k = 0; k < 3; k++) begin
			if (mem_we === 1'b1 && !ra_seen) begin
				ra_seen = 1'b1;
				check(mem_wdata, 16'h00A5);
			end
			step(1);
		end
		check(ra_seen, 1'b1);
		load(4'hF, 16'h1234);
		check(stack_pointer_register, 16'h1234);
		nesting_disable = 1'b1;
		sfr(3'b100, 16'hFFFF);
		check(alu_status[7:5], 3'h0);
		nesting_disable = 1'b0;
		sfr(3'b100, 16'hFFFF);
		check(alu_status, ccsc_pkg::ALU_STATUS_WMASK);
		check({user_irq_disabled, cpu_level}, 5'h17);
		sfr(3'b100, 16'h0000);
		sfr(3'b010, 16'hFFFF);
		check(cpu_control, 16'h0004);
		trap_take = 1'b1;
		step(1);
		trap_take = 1'b0;
		check(cpu_control, 16'h000C);
		check({user_irq_disabled, cpu_level}, 5'h18);
		sfr(3'b010, 16'h0004);
		check(cpu_control, 16'h0004);
		sfr(3'b001, 16'h005A);
		check(visibility_page_register, 8'h5A);
		data_addr = 16'h8123;
		step(1);
		check({psv_hit, psv_prog_addr}, {1'b1, 8'h5A, 15'h0123});
		data_addr = 16'h0123;
		step(1);
		check(psv_hit, 1'b0);
		sfr(3'b010, 16'h0000);
		data_addr = 16'h8123;
		step(1);
		check(psv_hit, 1'b0);
		final_report();
	end
endmodule : tb_top
